/* logic/msi_pkg.sv */
// msi generator constants and shared register map
// assumes one 100 MHz core clock shared by both ends
// Function
// R1 - programmable message id in write data
// R2 - programmable destination address for every write
// R3 - programmable delay before each message
// R4 - twelve ack, twelve overflow, eight av, two i2c, sixteen gpio
// R5 - edge detect with per-input polarity
// R6 - per-source enable; disabled source sends nothing
// R7 - legacy inta emulation as alternative
// R8 - requested count is power of two, max 32
// R9 - capability requests 32 before configuration
// R10 - software grants count; device uses only granted
// R11 - software sets address before enabling
// R12 - software sets message data value
// R13 - posted write to address with message data
// R14 - ack event on tagged last buffer element
// R15 - overflow events only for channels 1..12
// R16 - unmapped traffic class drop raises event
// R17 - av line held high until status cleared
// R18 - gpio inputs synchronised before edge detection
// R19 - gpio level held at least three cycles
// R20 - one request served at a time, sequentially
// R21 - pending latched, lowest index served first
// R22 - grant limits which low data bits change
package msi_pkg;
  // ----------------------------------------------------------------
  // source layout
  // ----------------------------------------------------------------
  localparam int N_DMA   = 12;
  localparam int N_AV    = 8;
  localparam int N_I2C   = 2;
  localparam int N_GPIO  = 16;
  localparam int N_SRC   = 2 * N_DMA + N_AV + N_I2C + 1 + N_GPIO;
  localparam int ID_W    = 6;
  localparam int CNT_W   = 16;
  localparam int MSG_W   = 16;
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int VEC_W   = 5;
  localparam int MME_W   = 3;
  localparam logic [MME_W-1:0] MMC_32 = 3'h5; // 32 messages requested
  localparam logic [MME_W-1:0] MME_MAX = 3'h5;

  // ----------------------------------------------------------------
  // controller register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int RA_W = 8;
  localparam logic [RA_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [RA_W-1:0] OFS_ADDR   = 8'h04;
  localparam logic [RA_W-1:0] OFS_DATA   = 8'h08;
  localparam logic [RA_W-1:0] OFS_DELAY  = 8'h0c;
  localparam logic [RA_W-1:0] OFS_EN_LO  = 8'h10;
  localparam logic [RA_W-1:0] OFS_EN_HI  = 8'h14;
  localparam logic [RA_W-1:0] OFS_POL_LO = 8'h18;
  localparam logic [RA_W-1:0] OFS_POL_HI = 8'h1c;
  localparam logic [RA_W-1:0] OFS_STAT   = 8'h20;
  localparam logic [RA_W-1:0] OFS_LAST   = 8'h24;
  localparam logic [RA_W-1:0] OFS_COUNT  = 8'h28;
  // ctrl fields
  localparam int CTRL_MSI_EN  = 0;
  localparam int CTRL_INTX_EN = 1;
  localparam int CTRL_MME_LO  = 2;
  localparam int CTRL_ACK     = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] RST_ZERO = 32'h0;
endpackage

/* logic/msi_link_if.sv */
// link between msi generator and the configuring / receiving end
// assumes both ends on one clock; no tri-state signals
`timescale 1ns/1ns
interface msi_link_if;
  import msi_pkg::*;
  // configuration from the controller end
  logic                  msi_en;
  logic                  intx_en;
  logic [MME_W-1:0]      mme;
  logic [ADDR_W-1:0]     msg_addr;
  logic [MSG_W-1:0]      msg_data;
  logic [CNT_W-1:0]      delay;
  logic [N_SRC-1:0]      src_en;
  logic [N_SRC-1:0]      src_pol;
  logic                  intx_ack;
  logic                  wr_ready;
  // from the generator end
  logic [MME_W-1:0]      cap_mmc;
  logic                  wr_valid;
  logic [ADDR_W-1:0]     wr_addr;
  logic [DATA_W-1:0]     wr_data;
  logic                  inta;

  modport gen (input msi_en, intx_en, mme, msg_addr, msg_data, delay, src_en, src_pol,
               intx_ack, wr_ready,
               output cap_mmc, wr_valid, wr_addr, wr_data, inta);
  modport ctl (output msi_en, intx_en, mme, msg_addr, msg_data, delay, src_en, src_pol,
               intx_ack, wr_ready,
               input cap_mmc, wr_valid, wr_addr, wr_data, inta);
endinterface

/* logic/msi_gen.sv */
// msi generator: edge detect, pending latch, one message at a time
// assumes controller end on the link drives configuration
`timescale 1ns/1ns
module msi_gen (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // event sources
  input  wire logic [msi_pkg::N_DMA-1:0] dma_ack,
  input  wire logic [msi_pkg::N_DMA-1:0] dma_ovf,
  input  wire logic [msi_pkg::N_AV-1:0]  av_irq,
  input  wire logic [msi_pkg::N_I2C-1:0] i2c_irq,
  input  wire logic                      tc_drop,
  input  wire logic [msi_pkg::N_GPIO-1:0] gpio_irq,
  // link
  msi_link_if.gen                        lnk
);
  import msi_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND, ST_INTX} gen_state_t;
  typedef struct packed {
    logic [N_GPIO-1:0] gpio_s1;
    logic [N_GPIO-1:0] gpio_s2;
    logic [N_SRC-1:0]  prev;
    logic [N_SRC-1:0]  pending;
    gen_state_t        state;
    logic [ID_W-1:0]   sel;
    logic [CNT_W-1:0]  cnt;
    logic              wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic              inta;
    logic [MME_W-1:0]  cap_mmc;
  } gen_s_t;

  gen_s_t            s_reg;
  gen_s_t            s_next;
  logic [N_SRC-1:0]  cur;
  logic [N_SRC-1:0]  edge_det;
  logic [N_SRC-1:0]  clr;
  logic              any_pend;
  logic [ID_W-1:0]   low_idx;
  logic [MSG_W-1:0]  grant_mask;
  logic [MSG_W-1:0]  vec;

  // source vector: ack, overflow, av, i2c, tc drop, synced gpio
  assign cur = {s_reg.gpio_s2, tc_drop, i2c_irq, av_irq, dma_ovf, dma_ack}; // [R4] [R14] [R15] [R16]

  // per-source polarity edge detect
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_edge
      assign edge_det[g] = lnk.src_en[g] &                                  // [R6]
                           (lnk.src_pol[g] ? (cur[g] & ~s_reg.prev[g])
                                           : (~cur[g] & s_reg.prev[g])); // [R5] [R17]
    end
  endgenerate

  // lowest pending index wins
  always_comb begin
    any_pend = 1'b0;
    low_idx  = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (s_reg.pending[i]) begin
        any_pend = 1'b1;                                                   // [R21]
        low_idx  = ID_W'(i);
      end
    end
  end

  // vector bits allowed by the grant
  assign grant_mask = MSG_W'((1 << lnk.mme) - 1);                          // [R10] [R22]
  assign vec        = MSG_W'(s_reg.sel[VEC_W-1:0]);

  // next-state logic
  always_comb begin
    s_next         = s_reg;
    clr            = '0;
    s_next.gpio_s1 = gpio_irq;                                             // [R18]
    s_next.gpio_s2 = s_reg.gpio_s1;
    s_next.prev    = cur;
    s_next.cap_mmc = MMC_32;                                               // [R8] [R9]
    case (s_reg.state)
      ST_IDLE: begin
        if (any_pend && (lnk.msi_en || lnk.intx_en)) begin                 // [R20]
          s_next.sel   = low_idx;
          s_next.cnt   = lnk.delay;
          s_next.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s_reg.cnt != '0) begin
          s_next.cnt = s_reg.cnt - CNT_W'(1);                              // [R3]
        end else if (lnk.intx_en) begin
          s_next.inta  = 1'b1;                                             // [R7]
          s_next.state = ST_INTX;
        end else begin
          s_next.wr_valid = 1'b1;
          s_next.wr_addr  = lnk.msg_addr;                                  // [R2] [R13]
          s_next.wr_data  = DATA_W'((lnk.msg_data & ~grant_mask) | (vec & grant_mask)); // [R1]
          s_next.state    = ST_SEND;
        end
      end
      ST_SEND: begin
        if (lnk.wr_ready) begin
          s_next.wr_valid = 1'b0;
          clr[s_reg.sel]  = 1'b1;                                          // [R21]
          s_next.state    = ST_IDLE;
        end
      end
      ST_INTX: begin
        if (lnk.intx_ack) begin
          s_next.inta    = 1'b0;
          clr[s_reg.sel] = 1'b1;
          s_next.state   = ST_IDLE;
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    // new edge beats clear in the same cycle
    s_next.pending = (s_reg.pending & ~clr) | edge_det;                    // [R21]
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cap_mmc <= MMC_32;
    end else begin
      s_reg <= s_next;
    end
  end

  // link outputs, all from flops
  assign lnk.cap_mmc  = s_reg.cap_mmc;
  assign lnk.wr_valid = s_reg.wr_valid;
  assign lnk.wr_addr  = s_reg.wr_addr;
  assign lnk.wr_data  = s_reg.wr_data;
  assign lnk.inta     = s_reg.inta;
endmodule // msi_gen

/* logic/msi_ctl.sv */
// controller end: axi4-lite registers configure the generator,
// accept its message writes and report them
// assumes one axi4-lite master, one write and one read at a time
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module msi_ctl (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // axi4-lite write
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [msi_pkg::RA_W-1:0]    awaddr,
  input  wire logic                        wvalid,
  output logic                             wready,
  input  wire logic [msi_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                  wstrb,
  output logic                             bvalid,
  input  wire logic                        bready,
  output logic [1:0]                       bresp,
  // axi4-lite read
  input  wire logic                        arvalid,
  output logic                             arready,
  input  wire logic [msi_pkg::RA_W-1:0]    araddr,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic [msi_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                       rresp,
  // link
  msi_link_if.ctl                          lnk
);
  import msi_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] delay;
    logic [63:0]       en;
    logic [63:0]       pol;
    logic              intx_ack;
    logic              wr_ready;
    logic [DATA_W-1:0] last;
    logic [DATA_W-1:0] count;
    logic              aw_got;
    logic              w_got;
    logic [RA_W-1:0]   aw_a;
    logic [DATA_W-1:0] w_d;
    logic [3:0]        w_s;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } ctl_s_t;

  ctl_s_t s_reg;
  ctl_s_t s_next;

  // byte-lane merge
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
                                              input logic [DATA_W-1:0] n,
                                              input logic [3:0]        st);
    logic [DATA_W-1:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // next-state logic
  always_comb begin
    s_next          = s_reg;
    s_next.intx_ack = 1'b0;
    s_next.wr_ready = 1'b1;
    // take generator writes and record them
    if (lnk.wr_valid && s_reg.wr_ready) begin                              // [R13]
      s_next.last  = lnk.wr_data;
      s_next.count = s_reg.count + DATA_W'(1);
    end
    // write address and data, either order
    if (awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_a   = awaddr;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.w_d   = wdata;
      s_next.w_s   = wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      case (s_reg.aw_a)
        OFS_CTRL: begin
          s_next.ctrl = merge(s_reg.ctrl, s_reg.w_d, s_reg.w_s);          // [R10] [R11]
          s_next.ctrl[CTRL_ACK] = 1'b0;
          s_next.intx_ack = s_reg.w_s[0] & s_reg.w_d[CTRL_ACK];           // [R7]
          if (s_next.ctrl[CTRL_MME_LO +: MME_W] > MME_MAX) begin
            s_next.ctrl[CTRL_MME_LO +: MME_W] = MME_MAX;                  // [R8]
          end
        end
        OFS_ADDR:   s_next.addr   = merge(s_reg.addr, s_reg.w_d, s_reg.w_s);   // [R11]
        OFS_DATA:   s_next.data   = merge(s_reg.data, s_reg.w_d, s_reg.w_s);   // [R12]
        OFS_DELAY:  s_next.delay  = merge(s_reg.delay, s_reg.w_d, s_reg.w_s);
        OFS_EN_LO:  s_next.en[31:0]  = merge(s_reg.en[31:0], s_reg.w_d, s_reg.w_s);
        OFS_EN_HI:  s_next.en[63:32] = merge(s_reg.en[63:32], s_reg.w_d, s_reg.w_s);
        OFS_POL_LO: s_next.pol[31:0]  = merge(s_reg.pol[31:0], s_reg.w_d, s_reg.w_s);
        OFS_POL_HI: s_next.pol[63:32] = merge(s_reg.pol[63:32], s_reg.w_d, s_reg.w_s);
        OFS_STAT, OFS_LAST, OFS_COUNT: s_next.bresp = RESP_OKAY;
        default:    s_next.bresp  = RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
    s_next.wready  = ~s_next.w_got & ~s_next.bvalid;
    // read path
    if (arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      case (araddr)
        OFS_CTRL:   s_next.rdata = s_reg.ctrl;
        OFS_ADDR:   s_next.rdata = s_reg.addr;
        OFS_DATA:   s_next.rdata = s_reg.data;
        OFS_DELAY:  s_next.rdata = s_reg.delay;
        OFS_EN_LO:  s_next.rdata = s_reg.en[31:0];
        OFS_EN_HI:  s_next.rdata = s_reg.en[63:32];
        OFS_POL_LO: s_next.rdata = s_reg.pol[31:0];
        OFS_POL_HI: s_next.rdata = s_reg.pol[63:32];
        OFS_STAT:   s_next.rdata = DATA_W'({lnk.inta, lnk.wr_valid, lnk.cap_mmc}); // [R9]
        OFS_LAST:   s_next.rdata = s_reg.last;
        OFS_COUNT:  s_next.rdata = s_reg.count;
        default: begin
          s_next.rdata = RST_ZERO;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = ~s_next.rvalid;
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs, all from flops
  assign awready      = s_reg.awready;
  assign wready       = s_reg.wready;
  assign bvalid       = s_reg.bvalid;
  assign bresp        = s_reg.bresp;
  assign arready      = s_reg.arready;
  assign rvalid       = s_reg.rvalid;
  assign rdata        = s_reg.rdata;
  assign rresp        = s_reg.rresp;
  assign lnk.msi_en   = s_reg.ctrl[CTRL_MSI_EN];
  assign lnk.intx_en  = s_reg.ctrl[CTRL_INTX_EN];
  assign lnk.mme      = s_reg.ctrl[CTRL_MME_LO +: MME_W];
  assign lnk.msg_addr = s_reg.addr;
  assign lnk.msg_data = s_reg.data[MSG_W-1:0];
  assign lnk.delay    = s_reg.delay[CNT_W-1:0];
  assign lnk.src_en   = s_reg.en[N_SRC-1:0];
  assign lnk.src_pol  = s_reg.pol[N_SRC-1:0];
  assign lnk.intx_ack = s_reg.intx_ack;
  assign lnk.wr_ready = s_reg.wr_ready;
endmodule // msi_ctl

/* verif/msi_assertions.sv */
// concurrent checks on the link between generator and controller
// assumes one clock; instantiated beside the link interface
`timescale 1ns/1ns
module msi_assertions (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // controller side
  input wire logic                       msi_en,
  input wire logic                       intx_en,
  input wire logic [msi_pkg::MME_W-1:0]  mme,
  input wire logic [msi_pkg::ADDR_W-1:0] msg_addr,
  input wire logic [msi_pkg::MSG_W-1:0]  msg_data,
  input wire logic [msi_pkg::CNT_W-1:0]  delay,
  input wire logic                       intx_ack,
  input wire logic                       wr_ready,
  // generator side
  input wire logic [msi_pkg::MME_W-1:0]  cap_mmc,
  input wire logic                       wr_valid,
  input wire logic [msi_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [msi_pkg::DATA_W-1:0] wr_data,
  input wire logic                       inta
);
  import msi_pkg::*;
  logic [MSG_W-1:0] vec_mask;
  logic [CNT_W:0]   gap_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // data bits the grant lets a source change
  assign vec_mask = (16'h1 << mme) - 16'h1;
  // idle cycles since the last message, saturating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) gap_reg <= '1;
    else if (wr_valid) gap_reg <= '0;
    else if (gap_reg != '1) gap_reg <= gap_reg + 1'b1;
  end
  property p_cap_req; cap_mmc == MMC_32; endproperty
  a_cap_req: assert property (p_cap_req)
    else $error("requested message count is not 32");
  property p_wr_addr; wr_valid |-> wr_addr == msg_addr; endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("message address differs from programmed one");
  property p_wr_upper; wr_valid |-> wr_data[31:16] == 16'h0; endproperty
  a_wr_upper: assert property (p_wr_upper)
    else $error("message data upper half not zero");
  property p_wr_share;
    wr_valid |-> ((wr_data[15:0] ^ msg_data) & ~vec_mask) == 16'h0;
  endproperty
  a_wr_share: assert property (p_wr_share)
    else $error("message data changed outside granted bits");
  property p_wr_gap; wr_valid && wr_ready |=> !wr_valid [*2]; endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("messages closer than one at a time");
  property p_one_kind; !(wr_valid && inta); endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("write and line interrupt at once");
  property p_kind_sel; $rose(wr_valid) |-> msi_en && !intx_en; endproperty
  a_kind_sel: assert property (p_kind_sel)
    else $error("write issued in wrong signalling mode");
  property p_delay; $rose(wr_valid) |-> gap_reg >= {1'b0, delay} + 17'd2; endproperty
  a_delay: assert property (p_delay)
    else $error("message sent before delay ran out");
  property p_inta_hold; inta && !intx_ack |=> inta; endproperty
  a_inta_hold: assert property (p_inta_hold)
    else $error("line interrupt dropped without acknowledge");
  property p_inta_clear; intx_ack |=> !inta; endproperty
  a_inta_clear: assert property (p_inta_clear)
    else $error("line interrupt kept after acknowledge");
endmodule // msi_assertions

/* verif/msi_interrupt_generator_tb_top.sv */
// bench: controller and generator joined by the link, driven over axi
// assumes the package, interface and both ends from logic/
`timescale 1ns/1ns
module msi_interrupt_generator_tb_top;
  import msi_pkg::*;
  localparam logic [31:0] MADDR = 32'h8000_1000;
  localparam logic [15:0] MDATA = 16'ha5e7;
  logic              core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [RA_W-1:0]   awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, got;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [N_SRC-1:0]  src_vec;
  logic [31:0]       msg_q[$];
  int                n_errors, n_checks, cyc;
  msi_link_if link ();
  msi_gen u_msi_gen (.core_clk(core_clk), .rst(rst), .dma_ack(src_vec[11:0]),
    .dma_ovf(src_vec[23:12]), .av_irq(src_vec[31:24]), .i2c_irq(src_vec[33:32]),
    .tc_drop(src_vec[34]), .gpio_irq(src_vec[50:35]), .lnk(link));
  msi_ctl u_msi_ctl (.core_clk(core_clk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .lnk(link));
  msi_assertions u_msi_assertions (.core_clk(core_clk), .rst(rst),
    .msi_en(link.msi_en), .intx_en(link.intx_en), .mme(link.mme),
    .msg_addr(link.msg_addr), .msg_data(link.msg_data), .delay(link.delay),
    .intx_ack(link.intx_ack), .wr_ready(link.wr_ready), .cap_mmc(link.cap_mmc),
    .wr_valid(link.wr_valid), .wr_addr(link.wr_addr), .wr_data(link.wr_data),
    .inta(link.inta));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard and message capture
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
    if (link.wr_valid === 1'b1 && link.wr_ready === 1'b1) begin
      msg_q.push_back(link.wr_data);
      check(link.wr_addr, MADDR);
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf, input logic [1:0] er = RESP_OKAY);
    logic aw_done, w_done;
    {aw_done, w_done} = 2'b00;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (awvalid && awready) aw_done = 1'b1;
      if (wvalid && wready) w_done = 1'b1;
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    check(bresp, er);
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    check(rdata, exp);
    check(rresp, er);
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  // toggle one source and hold it long enough for the gpio synchroniser
  task automatic ev(input int i);
    src_vec[i] <= ~src_vec[i];
    repeat (4) @(posedge core_clk);
  endtask
  function automatic logic [31:0] exp_msg(input int i, input int g);
    logic [15:0] m;
    m = (16'h1 << g) - 16'h1;
    return {16'h0, (MDATA & ~m) | (i[15:0] & m)};
  endfunction
  task automatic wait_msg(input logic [31:0] exp);
    int n;
    n = 0;
    while (msg_q.size() == 0 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    got = (msg_q.size() != 0) ? msg_q.pop_front() : 'x;
    check(got, exp);
  endtask
  task automatic quiet();
    repeat (30) @(posedge core_clk);
    check(msg_q.size(), 0);
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    src_vec = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_STAT, 32'h5);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, 4'hf, RESP_SLVERR);
    wr(OFS_ADDR, 32'hffff_ffff, 4'h1);
    rd(OFS_ADDR, 32'h0000_00ff);
    wr(OFS_ADDR, MADDR);
    wr(OFS_DATA, {16'h0, MDATA});
    wr(OFS_DELAY, 32'h0);
    wr(OFS_POL_LO, 32'hffff_ffff);
    wr(OFS_POL_HI, 32'h0007_ffff);
    wr(OFS_EN_LO, 32'hffff_ffff);
    wr(OFS_EN_HI, 32'h0007_ffff);
    wr(OFS_CTRL, 32'h15);
    rd(OFS_ADDR, MADDR);
    // every source, full grant
    for (int i = 0; i < N_SRC; i++) begin
      ev(i);
      wait_msg(exp_msg(i, 5));
      ev(i);
    end
    quiet();
    rd(OFS_COUNT, 32'd51);
    wr(OFS_CTRL, 32'h09);
    ev(34);
    wait_msg(exp_msg(34, 2));
    ev(34);
    wr(OFS_DELAY, 32'd40);
    ev(6);
    quiet();
    wait_msg(exp_msg(6, 2));
    ev(6);
    wr(OFS_DELAY, 32'h0);
    wr(OFS_POL_LO, 32'hffff_fff7);
    ev(3);
    quiet();
    ev(3);
    wait_msg(exp_msg(3, 2));
    wr(OFS_EN_LO, 32'hffff_ffdf);
    ev(5);
    quiet();
    ev(5);
    // two pending while sending is off, then lowest index first
    wr(OFS_CTRL, 32'h08);
    ev(9);
    ev(4);
    quiet();
    wr(OFS_CTRL, 32'h09);
    wait_msg(exp_msg(4, 2));
    wait_msg(exp_msg(9, 2));
    // line interrupt instead of writes
    wr(OFS_CTRL, 32'h0a);
    ev(1);
    quiet();
    rd(OFS_STAT, 32'h15);
    wr(OFS_CTRL, 32'h2a);
    repeat (3) @(posedge core_clk);
    check(link.inta, 1'b0);
    complete_run();
  end
endmodule // msi_interrupt_generator_tb_top
